/* File: core/ulmc_core.sv */
/*
  ulmc_core: one uart channel with format control, modem outputs, line
  status, a 4-deep receive fifo with error tags and a 16x baud engine.
  assumes a plain register port (read data one cycle later) and
  serial inputs already synchronous to i_clk_sys.
*/
// Function
// - word length 5 to 8, default 5
// - stop select: 1, 1.5 or 2 bits
// - parity enable adds and checks parity
// - odd, even, mark or space parity
// - break holds transmit output low outside loopback and infrared
// - divisor access selects divisor latches
// - bit0 drives terminal ready, inverted, except in loopback
// - bit1 drives request to send, inverted, unless loopback or auto flow
// - bit2 feeds internal ring indicator in loopback
// - bit3 or select pin enables irq
// - bit4 enables internal loopback
// - xon-any resumes halted transmit
// - infrared encode and decode, idle low
// - prescaler divides clock by four
// - overrun irq now, tags at head
// - ready bit while data waits
// - overrun drops character, fifo intact
// - parity/framing flags describe head character
// - break loads one character, holds
// - holding empty set on load out
// - idle only when both stages empty
// - error summary while tagged entries remain
// - enhanced bits writable only when enabled
// - status read clears line interrupt
`timescale 1ns/10ps
`default_nettype none
module ulmc_core (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // host register port
  input wire ulmc_pkg::ulmc_bus_t i_bus,
  output logic [7:0] o_rdata,
  // serial and modem side
  input wire logic i_rxd,
  input wire logic i_ring_indicator_in_n,
  input wire logic i_interrupt_mode_select_pin,
  output ulmc_pkg::ulmc_line_t o_line
);
  import ulmc_pkg::*;

  ulmc_state_t r_reg;
  ulmc_state_t r_next;

  // masks bits above the word length
  function automatic logic [7:0] wmask(input logic [7:0] d,
                                       input logic [1:0] wl);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - wl);
    return d & m;
  endfunction

  // parity bit for the current format
  function automatic logic par_of(input logic [7:0] d,
                                  input logic [7:0] lfc);
    logic p;
    if (lfc[LFC_FORCE]) begin
      p = ~lfc[LFC_EVEN];
    end else begin
      p = (^wmask(d, lfc[1:0])) ^ ~lfc[LFC_EVEN];
    end
    return p;
  endfunction

  always_comb begin
    logic [7:0] lfc;
    logic [7:0] moc;
    logic [7:0] ien;
    logic [7:0] efc;
    logic [15:0] div;
    logic [15:0] dm1;
    logic pre_tick;
    logic tick;
    logic dlab;
    logic enh;
    logic loop;
    logic ir;
    logic txb;
    logic rxl;
    logic done;
    logic c_fe;
    logic c_brk;
    logic swfc;
    logic do_push;
    logic hv;
    logic [2:0] wlast;
    logic [5:0] stop_last;
    logic [7:0] lst;
    ulmc_rx_ent_t head;
    ulmc_rx_ent_t ent;
    ulmc_rx_ent_t nhead;
    r_next = r_reg;
    lfc = r_reg.line_format_control;
    moc = r_reg.modem_output_control;
    ien = r_reg.interrupt_enable_control;
    efc = r_reg.enhanced_feature_control;
    div = {r_reg.divisor_high, r_reg.divisor_low};
    dm1 = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
    dlab = lfc[LFC_DLAB];
    enh = efc[EFC_ENH];
    loop = moc[MOC_LOOP];
    ir = moc[MOC_IR];
    wlast = WLEN_BASE + {1'b0, lfc[1:0]};
    stop_last = ~lfc[LFC_STOP] ? STOP1_LAST :
                (lfc[1:0] == 2'h0) ? STOP15_LAST : STOP2_LAST;
    txb = 1'b1;
    rxl = 1'b1;
    done = 1'b0;
    c_fe = 1'b0;
    c_brk = 1'b0;
    do_push = 1'b0;
    swfc = efc[1:0] != 2'h0;
    ent = '0;
    head = r_reg.mem[r_reg.rd_ptr];
    hv = r_reg.cnt != 3'h0;

    r_next.pre_cnt = r_reg.pre_cnt + 2'h1;
    pre_tick = moc[MOC_PRE] ? (r_reg.pre_cnt == PRE_LAST) : 1'b1;
    tick = pre_tick && (r_reg.baud_cnt >= dm1);
    if (pre_tick) begin
      r_next.baud_cnt = tick ? 16'h0000 : r_reg.baud_cnt + 16'h0001;
    end

    // transmit line bit
    case (r_reg.tx_st)
      ST_START: txb = 1'b0;
      ST_DATA: txb = r_reg.transmit_shift[r_reg.tx_bit];
      ST_PAR: txb = par_of(r_reg.transmit_shift, lfc);
      default: txb = 1'b1;
    endcase
    if (lfc[LFC_BRK]) begin
      txb = 1'b0;
    end

    if (i_rxd) begin
      r_next.ir_hold = IR_STRETCH;
    end else if (tick && r_reg.ir_hold != 5'h00) begin
      r_next.ir_hold = r_reg.ir_hold - 5'h01;
    end
    if (loop) begin
      rxl = txb;
    end else if (ir) begin
      rxl = r_reg.ir_hold == 5'h00;
    end else begin
      rxl = i_rxd;
    end

    // receiver
    if (tick) begin
      r_next.rx_tcnt = r_reg.rx_tcnt + 4'h1;
    end
    case (r_reg.rx_st)
      ST_IDLE: begin
        r_next.rx_tcnt = 4'h0;
        if (!rxl) begin
          r_next.rx_st = ST_START;
        end
      end
      ST_START: begin
        if (tick && r_reg.rx_tcnt == START_MID) begin
          r_next.rx_tcnt = 4'h0;
          r_next.rx_bit = 3'h0;
          r_next.rx_sh = 8'h00;
          r_next.rx_zero = 1'b1;
          r_next.rx_pe = 1'b0;
          r_next.rx_st = rxl ? ST_IDLE : ST_DATA;
        end
      end
      ST_DATA: begin
        if (tick && r_reg.rx_tcnt == TICK_LAST) begin
          r_next.rx_sh[r_reg.rx_bit] = rxl;
          r_next.rx_zero = r_reg.rx_zero & ~rxl;
          r_next.rx_bit = r_reg.rx_bit + 3'h1;
          if (r_reg.rx_bit == wlast) begin
            r_next.rx_st = lfc[LFC_PEN] ? ST_PAR : ST_STOP;
          end
        end
      end
      ST_PAR: begin
        if (tick && r_reg.rx_tcnt == TICK_LAST) begin
          r_next.rx_pe = rxl != par_of(r_reg.rx_sh, lfc);
          r_next.rx_zero = r_reg.rx_zero & ~rxl;
          r_next.rx_st = ST_STOP;
        end
      end
      ST_STOP: begin
        if (tick && r_reg.rx_tcnt == TICK_LAST) begin
          done = 1'b1;
          c_fe = ~rxl;
          // whole frame low is a break
          c_brk = r_reg.rx_zero & ~rxl;
          r_next.rx_st = c_brk ? ST_BRK : ST_IDLE;
        end
      end
      ST_BRK: begin
        // one break entry, then wait for mark
        if (rxl) begin
          r_next.rx_st = ST_IDLE;
        end
      end
      default: r_next.rx_st = ST_IDLE;
    endcase

    // completed character and software flow
    if (done) begin
      ent.data = c_brk ? 8'h00 : r_reg.rx_sh;
      ent.pe = r_reg.rx_pe & ~c_brk;
      ent.fe = c_fe;
      ent.brk = c_brk;
      if (swfc && ent.data == r_reg.xoff_char && !c_fe) begin
        r_next.tx_halt = 1'b1;
      end else if (swfc && ent.data == r_reg.xon_char && !c_fe) begin
        r_next.tx_halt = 1'b0;
      end else begin
        // any character resumes and is kept
        if (moc[MOC_XANY]) begin
          r_next.tx_halt = 1'b0;
        end
        do_push = 1'b1;
      end
    end

    // fifo pop on data read
    if (i_bus.rd && i_bus.addr == OFS_DATA && !dlab && hv) begin
      r_next.rd_ptr = r_reg.rd_ptr + 2'h1;
      r_next.cnt = r_reg.cnt - 3'h1;
      if (head.pe || head.fe || head.brk) begin
        r_next.err_cnt = r_reg.err_cnt - 3'h1;
      end
    end
    if (do_push) begin
      if (r_next.cnt == FIFO_DEPTH) begin
        r_next.overrun = 1'b1;
        r_next.lsi_pend = 1'b1;
      end else begin
        r_next.mem[r_reg.wr_ptr] = ent;
        r_next.wr_ptr = r_reg.wr_ptr + 2'h1;
        r_next.cnt = r_next.cnt + 3'h1;
        if (ent.pe || ent.fe || ent.brk) begin
          r_next.err_cnt = r_next.err_cnt + 3'h1;
        end
      end
    end

    // transmitter
    if (tick) begin
      r_next.tx_tcnt = r_reg.tx_tcnt + 6'h01;
    end
    case (r_reg.tx_st)
      ST_IDLE: begin
        if (tick && r_reg.tx_tcnt == TX_BIT_LAST) begin
          r_next.tx_tcnt = 6'h00;
        end
        if (r_reg.thr_full && !r_reg.tx_halt) begin
          r_next.transmit_shift = r_reg.transmit_holding;
          r_next.thr_full = 1'b0;
          r_next.tx_tcnt = 6'h00;
          r_next.tx_st = ST_START;
        end
      end
      ST_START: begin
        if (tick && r_reg.tx_tcnt == TX_BIT_LAST) begin
          r_next.tx_tcnt = 6'h00;
          r_next.tx_bit = 3'h0;
          r_next.tx_st = ST_DATA;
        end
      end
      ST_DATA: begin
        if (tick && r_reg.tx_tcnt == TX_BIT_LAST) begin
          r_next.tx_tcnt = 6'h00;
          r_next.tx_bit = r_reg.tx_bit + 3'h1;
          if (r_reg.tx_bit == wlast) begin
            r_next.tx_st = lfc[LFC_PEN] ? ST_PAR : ST_STOP;
          end
        end
      end
      ST_PAR: begin
        if (tick && r_reg.tx_tcnt == TX_BIT_LAST) begin
          r_next.tx_tcnt = 6'h00;
          r_next.tx_st = ST_STOP;
        end
      end
      ST_STOP: begin
        if (tick && r_reg.tx_tcnt == stop_last) begin
          r_next.tx_tcnt = 6'h00;
          r_next.tx_st = ST_IDLE;
        end
      end
      default: r_next.tx_st = ST_IDLE;
    endcase

    // line status image
    // status bits
    lst = {r_reg.err_cnt != 3'h0,
           ~r_reg.thr_full && r_reg.tx_st == ST_IDLE,
           ~r_reg.thr_full,
           hv & head.brk, hv & head.fe, hv & head.pe,
           r_reg.overrun, hv};

    // register read, data one cycle later
    r_next.rdata = RST_BYTE;
    if (i_bus.rd) begin
      case (i_bus.addr)
        OFS_DATA: r_next.rdata = dlab ? r_reg.divisor_low : head.data;
        OFS_IEN: r_next.rdata = dlab ? r_reg.divisor_high : ien;
        OFS_EFC: r_next.rdata = dlab ? r_reg.divisor_fraction : efc;
        OFS_LFC: r_next.rdata = lfc;
        OFS_MOC: r_next.rdata = moc;
        OFS_LST: r_next.rdata = lst;
        OFS_XON: r_next.rdata = r_reg.xon_char;
        OFS_XOFF: r_next.rdata = r_reg.xoff_char;
        default: r_next.rdata = RST_BYTE;
      endcase
      if (i_bus.addr == OFS_LST) begin
        r_next.overrun = r_next.overrun & ~r_reg.overrun;
        r_next.lsi_pend = r_next.lsi_pend & ~r_reg.lsi_pend;
        if (do_push && r_next.cnt == FIFO_DEPTH && r_reg.cnt == FIFO_DEPTH) begin
          r_next.overrun = 1'b1;
          r_next.lsi_pend = 1'b1;
        end
      end
    end

    nhead = r_next.mem[r_next.rd_ptr];
    if (r_next.cnt != 3'h0 && (r_next.rd_ptr != r_reg.rd_ptr || !hv)
        && (nhead.pe || nhead.fe || nhead.brk)) begin
      r_next.lsi_pend = 1'b1;
    end

    // register write
    if (i_bus.wr) begin
      case (i_bus.addr)
        OFS_DATA: begin
          if (dlab) begin
            r_next.divisor_low = i_bus.wdata;
          end else begin
            r_next.transmit_holding = i_bus.wdata;
            r_next.thr_full = 1'b1;
          end
        end
        OFS_IEN: begin
          if (dlab) begin
            r_next.divisor_high = i_bus.wdata;
          end else if (enh) begin
            r_next.interrupt_enable_control = i_bus.wdata;
          end else begin
            r_next.interrupt_enable_control =
              (ien & IEN_ENH_MASK) | (i_bus.wdata & ~IEN_ENH_MASK);
          end
        end
        OFS_EFC: begin
          if (!dlab) begin
            r_next.enhanced_feature_control = i_bus.wdata;
          end else if (enh) begin
            r_next.divisor_fraction = i_bus.wdata;
          end
        end
        OFS_LFC: r_next.line_format_control = i_bus.wdata;
        OFS_MOC: begin
          if (enh) begin
            r_next.modem_output_control = i_bus.wdata;
          end else begin
            r_next.modem_output_control =
              (moc & MOC_ENH_MASK) | (i_bus.wdata & ~MOC_ENH_MASK);
          end
        end
        OFS_XON: r_next.xon_char = i_bus.wdata;
        OFS_XOFF: r_next.xoff_char = i_bus.wdata;
        default: r_next.xoff_char = r_reg.xoff_char;
      endcase
    end

    // registered pins
    // infrared: short high pulse per zero
    if (loop) begin
      r_next.line.txd = ~ir;
    end else if (ir) begin
      r_next.line.txd = ~txb && (r_reg.tx_tcnt < IR_PULSE);
    end else begin
      r_next.line.txd = txb;
    end
    r_next.line.terminal_ready_n = loop | ~moc[MOC_DTR];
    // auto flow overrides request to send
    if (loop) begin
      r_next.line.request_to_send_n = 1'b1;
    end else if (efc[EFC_ARTS]) begin
      r_next.line.request_to_send_n = r_reg.cnt >= RTS_OFF_LVL;
    end else begin
      r_next.line.request_to_send_n = ~moc[MOC_RTS];
    end
    r_next.line.irq = r_reg.lsi_pend & ien[IEN_LSI];
    r_next.line.irq_oe = moc[MOC_IEN] | i_interrupt_mode_select_pin;
    r_next.line.loopback_output_two_n = ~(loop & moc[MOC_IEN]);
    r_next.line.ring_seen = loop ? moc[MOC_OP1] : ~i_ring_indicator_in_n;
  end

  // all state in one register; pins reset to mark/inactive
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      r_reg <= '0;
      r_reg.line <= LINE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_rdata = r_reg.rdata;
  assign o_line = r_reg.line;
endmodule // ulmc_core
`default_nettype wire

/* File: core/ulmc_pkg.sv */
/*
  ulmc_pkg: constants, register map and carrier types for one uart channel
  (line format, modem outputs, line status).
  assumes a single 250 MHz system clock and a plain byte-wide register port.
*/
package ulmc_pkg;
  // register offsets (divisor access remaps 0..2)
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IEN = 3'h1;
  localparam logic [2:0] OFS_EFC = 3'h2;
  localparam logic [2:0] OFS_LFC = 3'h3;
  localparam logic [2:0] OFS_MOC = 3'h4;
  localparam logic [2:0] OFS_LST = 3'h5;
  localparam logic [2:0] OFS_XON = 3'h6;
  localparam logic [2:0] OFS_XOFF = 3'h7;
  // line_format_control fields
  localparam int LFC_STOP = 2;
  localparam int LFC_PEN = 3;
  localparam int LFC_EVEN = 4;
  localparam int LFC_FORCE = 5;
  localparam int LFC_BRK = 6;
  localparam int LFC_DLAB = 7;
  // modem_output_control fields
  localparam int MOC_DTR = 0;
  localparam int MOC_RTS = 1;
  localparam int MOC_OP1 = 2;
  localparam int MOC_IEN = 3;
  localparam int MOC_LOOP = 4;
  localparam int MOC_XANY = 5;
  localparam int MOC_IR = 6;
  localparam int MOC_PRE = 7;
  // interrupt_enable_control and enhanced_feature_control fields
  localparam int IEN_LSI = 2;
  localparam int EFC_ENH = 4;
  localparam int EFC_ARTS = 6;
  localparam logic [7:0] MOC_ENH_MASK = 8'hE0;
  localparam logic [7:0] IEN_ENH_MASK = 8'hF0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // timing in 16x sample ticks and prescaler steps
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] START_MID = 4'h7;
  localparam logic [5:0] TX_BIT_LAST = 6'h0F;
  localparam logic [5:0] STOP1_LAST = 6'h0F;
  localparam logic [5:0] STOP15_LAST = 6'h17;
  localparam logic [5:0] STOP2_LAST = 6'h1F;
  localparam logic [5:0] IR_PULSE = 6'h03;
  localparam logic [4:0] IR_STRETCH = 5'h10;
  localparam logic [1:0] PRE_LAST = 2'h3;
  localparam logic [2:0] WLEN_BASE = 3'h4;
  // receive fifo
  localparam logic [2:0] FIFO_DEPTH = 3'h4;
  localparam logic [2:0] RTS_OFF_LVL = 3'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_START = 3'b001, ST_DATA = 3'b010,
    ST_PAR = 3'b011, ST_STOP = 3'b100, ST_BRK = 3'b101
  } ulmc_ser_t;

  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } ulmc_rx_ent_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ulmc_bus_t;

  typedef struct packed {
    logic txd;
    logic terminal_ready_n;
    logic request_to_send_n;
    logic irq;
    logic irq_oe;
    logic ring_seen;
    logic loopback_output_two_n;
  } ulmc_line_t;

  localparam ulmc_line_t LINE_RST = '{txd: 1'b1, terminal_ready_n: 1'b1,
    request_to_send_n: 1'b1, irq: 1'b0, irq_oe: 1'b0, ring_seen: 1'b0,
    loopback_output_two_n: 1'b1};

  typedef struct packed {
    logic [7:0] line_format_control;
    logic [7:0] modem_output_control;
    logic [7:0] interrupt_enable_control;
    logic [7:0] enhanced_feature_control;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] divisor_fraction;
    logic [7:0] xon_char;
    logic [7:0] xoff_char;
    logic [1:0] pre_cnt;
    logic [15:0] baud_cnt;
    ulmc_ser_t tx_st;
    logic [7:0] transmit_holding;
    logic thr_full;
    logic [7:0] transmit_shift;
    logic [2:0] tx_bit;
    logic [5:0] tx_tcnt;
    logic tx_halt;
    ulmc_ser_t rx_st;
    logic [7:0] rx_sh;
    logic [2:0] rx_bit;
    logic [3:0] rx_tcnt;
    logic rx_pe;
    logic rx_zero;
    logic [4:0] ir_hold;
    ulmc_rx_ent_t [3:0] mem;
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    logic [2:0] cnt;
    logic [2:0] err_cnt;
    logic overrun;
    logic lsi_pend;
    logic [7:0] rdata;
    ulmc_line_t line;
  } ulmc_state_t;
endpackage

/* File: tb/ulmc_core_bench.sv */
/*
  ulmc_core_bench: register-level tests of ulmc_core against a remote partner.
  assumes divisor 0 (16 clocks a bit) unless the prescaler is on.
*/
`timescale 1ns/10ps
`default_nettype none
module ulmc_core_bench;
  import ulmc_pkg::*;
  logic i_clk_sys;
  logic i_resetn;
  ulmc_bus_t bus_q;
  logic [7:0] rdata;
  logic rxd;
  logic ring_n;
  logic isel;
  ulmc_line_t line;
  int fails;
  int total_checks;
  int n;
  logic [31:0] e;
  logic [7:0] v;
  logic [7:0] cfg [5] = '{8'h00, 8'h0B, 8'h1A, 8'h29, 8'h3F};
  logic [7:0] lst_x [3] = '{8'h61, 8'hE5, 8'hE9};
  ulmc_core ulmc_core_inst (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_bus(bus_q),
    .o_rdata(rdata),
    .i_rxd(rxd),
    .i_ring_indicator_in_n(ring_n),
    .i_interrupt_mode_select_pin(isel),
    .o_line(line)
  );
  ulmc_partner ulmc_partner_inst (
    .i_clk_sys(i_clk_sys),
    .i_txd(line.txd),
    .o_rxd(rxd)
  );
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  task automatic results();
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    bus_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    bus_q.wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    bus_q <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    bus_q.rd <= 1'b0;
    #1 v = rdata;
    chk(32'(v), 32'(exp));
  endtask
  task automatic tick(input int nn);
    repeat (nn) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic put(input logic b);
    e[n] = b;
    n = n + 1;
  endtask
  // expected frame: start, lsb-first data, parity, stop bits
  task automatic mk(input logic [7:0] l, input logic [7:0] d);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - l[1:0]);
    put(1'b0);
    for (int i = 0; i < 5 + int'(l[1:0]); i++) begin
      put(d[i]);
    end
    if (l[3]) begin
      put(l[5] ? !l[4] : ((^(d & m)) ^ !l[4]));
    end
    put(1'b1);
    if (l[2]) begin
      put(1'b1);
    end
  endtask
  // watchdog well beyond the expected run of about 5600 clocks
  initial begin
    repeat (40000) @(posedge i_clk_sys);
    fails++;
    results();
  end
  initial begin
    i_resetn = 1'b0;
    bus_q = '0;
    ring_n = 1'b1;
    isel = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (5) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    rdchk(OFS_LFC, 8'h00);
    rdchk(OFS_MOC, 8'h00);
    rdchk(OFS_LST, 8'h60);
    chk(32'(line.terminal_ready_n), 32'h1);
    wr(OFS_LST, 8'hFF);
    rdchk(OFS_LST, 8'h60);
    wr(OFS_MOC, 8'hE3);
    tick(2);
    chk(32'({line.terminal_ready_n, line.request_to_send_n}), 32'h0);
    rdchk(OFS_MOC, 8'h03);
    wr(OFS_EFC, 8'h10);
    wr(OFS_MOC, 8'h20);
    wr(OFS_EFC, 8'h00);
    wr(OFS_MOC, 8'h00);
    rdchk(OFS_MOC, 8'h20);
    wr(OFS_LFC, 8'h80);
    wr(OFS_DATA, 8'h5A);
    rdchk(OFS_DATA, 8'h5A);
    wr(OFS_DATA, 8'h00);
    wr(OFS_LFC, 8'h00);
    rdchk(OFS_LST, 8'h60);
    foreach (cfg[k]) begin
      wr(OFS_LFC, cfg[k]);
      e = '1;
      n = 0;
      mk(cfg[k], cfg[k] ^ 8'h96);
      mk(cfg[k], 8'h3C);
      fork
        ulmc_partner_inst.grab(24, 16);
        begin
          wr(OFS_DATA, cfg[k] ^ 8'h96);
          wr(OFS_DATA, 8'h3C);
        end
      join
      chk(ulmc_partner_inst.cap, e);
    end
    wr(OFS_LFC, 8'h43);
    tick(40);
    chk(32'(line.txd), 32'h0);
    wr(OFS_LFC, 8'h03);
    tick(2);
    chk(32'(line.txd), 32'h1);
    wr(OFS_EFC, 8'h10);
    wr(OFS_MOC, 8'h80);
    e = '1;
    n = 0;
    mk(8'h03, 8'hA5);
    fork
      ulmc_partner_inst.grab(12, 64);
      wr(OFS_DATA, 8'hA5);
    join
    chk(ulmc_partner_inst.cap, e);
    wr(OFS_MOC, 8'h00);
    wr(OFS_LFC, 8'h1B);
    for (int j = 0; j < 3; j++) begin
      e = '1;
      n = 0;
      mk(8'h1B, 8'hA5);
      if (j > 0) begin
        e[8 + j] = ~e[8 + j];
      end
      ulmc_partner_inst.send(e, n);
      tick(4);
      rdchk(OFS_LST, lst_x[j]);
      rdchk(OFS_DATA, 8'hA5);
      rdchk(OFS_LST, 8'h60);
    end
    ulmc_partner_inst.send(32'h0, 24);
    tick(4);
    rdchk(OFS_LST, 8'hF9);
    rdchk(OFS_DATA, 8'h00);
    rdchk(OFS_LST, 8'h60);
    wr(OFS_IEN, 8'h04);
    for (int j = 0; j < 5; j++) begin
      e = '1;
      n = 0;
      mk(8'h1B, 8'h10 | 8'(j));
      ulmc_partner_inst.send(e, n);
    end
    tick(4);
    chk(32'(line.irq), 32'h1);
    rdchk(OFS_LST, 8'h63);
    tick(2);
    chk(32'(line.irq), 32'h0);
    rdchk(OFS_LST, 8'h61);
    for (int j = 0; j < 4; j++) begin
      rdchk(OFS_DATA, 8'h10 | 8'(j));
    end
    rdchk(OFS_LST, 8'h60);
    wr(OFS_XOFF, 8'h13);
    wr(OFS_EFC, 8'h11);
    wr(OFS_MOC, 8'h20);
    e = '1;
    n = 0;
    mk(8'h1B, 8'h13);
    ulmc_partner_inst.send(e, n);
    tick(4);
    wr(OFS_DATA, 8'h77);
    tick(4);
    rdchk(OFS_LST, 8'h00);
    e = '1;
    n = 0;
    mk(8'h1B, 8'h44);
    ulmc_partner_inst.send(e, n);
    tick(4);
    rdchk(OFS_DATA, 8'h44);
    rdchk(OFS_LST, 8'h20);
    wr(OFS_EFC, 8'h10);
    tick(200);
    wr(OFS_MOC, 8'h1C);
    tick(2);
    chk(32'({line.loopback_output_two_n, line.ring_seen}), 32'h1);
    wr(OFS_DATA, 8'h5A);
    rdchk(OFS_LST, 8'h20);
    tick(220);
    rdchk(OFS_DATA, 8'h5A);
    wr(OFS_MOC, 8'h00);
    @(posedge i_clk_sys);
    isel <= 1'b1;
    tick(2);
    chk(32'(line.irq_oe), 32'h1);
    wr(OFS_MOC, 8'h40);
    tick(3);
    chk(32'(line.txd), 32'h0);
    results();
  end
endmodule // ulmc_core_bench
`default_nettype wire

/* File: tb/ulmc_monitor.sv */
/*
  ulmc_monitor: port-level checks for ulmc_core, bound into it.
  assumes all register writes reach the core over its plain register port.
*/
`timescale 1ns/10ps
`default_nettype none
module ulmc_monitor
  import ulmc_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // host register port
  input wire ulmc_pkg::ulmc_bus_t i_bus,
  input wire logic [7:0] o_rdata,
  // serial and modem side
  input wire logic i_rxd,
  input wire logic i_ring_indicator_in_n,
  input wire logic i_interrupt_mode_select_pin,
  input wire ulmc_pkg::ulmc_line_t o_line
);
  logic [7:0] lfc_reg;
  logic [4:0] moc_reg;
  logic arts_reg;
  logic [1:0] age_reg;
  // shadow of host writes; pin-fed outputs trusted only once age saturates
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      lfc_reg <= 8'h00;
      moc_reg <= 5'h00;
      arts_reg <= 1'b0;
      age_reg <= 2'h0;
    end else begin
      if (i_bus.wr && i_bus.addr == OFS_LFC) begin
        lfc_reg <= i_bus.wdata;
      end
      if (i_bus.wr && i_bus.addr == OFS_MOC) begin
        moc_reg <= i_bus.wdata[4:0];
      end
      if (i_bus.wr && i_bus.addr == OFS_EFC && !lfc_reg[7]) begin
        arts_reg <= i_bus.wdata[EFC_ARTS];
      end
      if (age_reg != 2'h3) begin
        age_reg <= age_reg + 2'h1;
      end
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  AST_DTR_LEVEL: assert property (o_line.terminal_ready_n == ($past(moc_reg[4]) || !$past(moc_reg[0])))
    else $error("terminal ready level wrong");
  AST_RTS_LEVEL: assert property (!$past(arts_reg) |->
    o_line.request_to_send_n == ($past(moc_reg[4]) || !$past(moc_reg[1])))
    else $error("request to send level wrong");
  AST_RING_SRC: assert property (age_reg == 2'h3 |->
    o_line.ring_seen == ($past(moc_reg[4]) ? $past(moc_reg[2]) : !$past(i_ring_indicator_in_n)))
    else $error("internal ring source wrong");
  AST_IRQ_OE: assert property (age_reg == 2'h3 |->
    o_line.irq_oe == ($past(moc_reg[3]) || $past(i_interrupt_mode_select_pin)))
    else $error("irq enable wrong");
  AST_OP2_LOOP: assert property (moc_reg[4] && moc_reg[3] |=> !o_line.loopback_output_two_n)
    else $error("second loopback output not low");
  AST_LOOP_TXD: assert property (moc_reg[4] && !lfc_reg[6] |=> o_line.txd)
    else $error("txd not idle in loopback");
  AST_BREAK_TXD: assert property (lfc_reg[6] && !moc_reg[4] |=> !o_line.txd)
    else $error("txd not low during break");
  AST_LFC_READ: assert property (i_bus.rd && i_bus.addr == OFS_LFC |=> o_rdata == $past(lfc_reg))
    else $error("line format readback wrong");
  AST_IDLE_FLAG: assert property (i_bus.rd && i_bus.addr == OFS_LST |=> o_rdata[5] || !o_rdata[6])
    else $error("idle flag set with holding full");
endmodule // ulmc_monitor
bind ulmc_core ulmc_monitor ulmc_monitor_inst (
  .i_clk_sys(i_clk_sys),
  .i_resetn(i_resetn),
  .i_bus(i_bus),
  .o_rdata(o_rdata),
  .i_rxd(i_rxd),
  .i_ring_indicator_in_n(i_ring_indicator_in_n),
  .i_interrupt_mode_select_pin(i_interrupt_mode_select_pin),
  .o_line(o_line)
);
`default_nettype wire

/* File: tb/ulmc_partner.sv */
/*
  ulmc_partner: remote serial device, sends bit vectors and samples txd.
  assumes the caller gives the bit period in system clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module ulmc_partner (
  // clock
  input wire logic i_clk_sys,
  // serial lines
  input wire logic i_txd,
  output logic o_rxd
);
  logic [31:0] cap;
  initial o_rxd = 1'b1;
  // lsb first, 16 clocks a bit, line back to mark after
  task automatic send(input logic [31:0] b, input int nb);
    for (int i = 0; i < nb; i++) begin
      @(posedge i_clk_sys);
      o_rxd <= b[i];
      repeat (15) @(posedge i_clk_sys);
    end
    @(posedge i_clk_sys);
    o_rxd <= 1'b1;
  endtask
  // mid-bit sampling from the start edge; unsampled bits read as mark
  task automatic grab(input int nb, input int per);
    cap = '1;
    @(negedge i_txd);
    repeat (per / 2) @(posedge i_clk_sys);
    for (int i = 0; i < nb; i++) begin
      #1 cap[i] = i_txd;
      repeat (per) @(posedge i_clk_sys);
    end
  endtask
endmodule // ulmc_partner
`default_nettype wire
